// [logic/uart_config_command_interpreter.sv]
// Serial command interpreter: EEPROM and RAM access, soft reset, boot
// checksum, mode decode, limiting, level steering and clock trim choice.
// Assumes a 20 MHz mclk, synchronous high rst and a host that waits for
// each echo or reply before sending the next byte.
`timescale 1ns/1ps
`default_nettype none
module uart_config_command_interpreter #(
  parameter int unsigned SLOW_BIT_CYCLES = uart_cfg_pkg::SLOW_BIT_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        serial_rx,
  output logic             serial_tx,
  input  wire logic        baud_select,
  input  wire logic [15:0] internal_temp_adc,
  input  wire logic [9:0]  filtered_temp,
  input  wire logic [15:0] gain_stage_adc,
  input  wire logic [7:0]  signal_level,
  input  wire logic        aux_pin_a_in,
  input  wire logic        aux_pin_b_in,
  output logic             aux_pin_a_out,
  output logic             aux_pin_a_oe_n,
  output logic             aux_pin_b_out,
  output logic             aux_pin_b_oe_n,
  output logic             config_ready,
  output logic             checksum_fail,
  output logic             digital_mode,
  output logic             mode_conflict,
  output logic             limit_enable,
  output logic             level_steer_enable,
  output logic             turbo_enable,
  output logic             voltage_output_enable,
  output logic             current_loop_output_enable,
  output logic             external_temp_select,
  output logic             current_loop_fixed,
  output logic [9:0]       current_loop_value,
  output logic             digital_output_override,
  output logic [9:0]       output_value,
  output logic [7:0]       clock_trim,
  output logic [11:0]      gain_tc1,
  output logic [11:0]      offset_tc1
);
  typedef enum logic [4:0] {
    S_BOOT  = 5'h01,
    S_IDLE  = 5'h02,
    S_TX    = 5'h04,
    S_WDATA = 5'h08,
    S_SOFT  = 5'h10
  } core_state_t;

  typedef struct packed {
    core_state_t      st;
    core_state_t      after;
    logic [47:0][7:0] ee;
    logic [47:0][7:0] cfg;
    logic [63:0][7:0] ram;
    logic [5:0]       idx;
    logic [7:0]       sum;
    logic             wr_ee;
    logic [7:0]       tx_byte;
    logic [1:0]       tx_left;
    logic             fail;
    logic [7:0]       trim;
    logic             override;
    logic [9:0]       value;
    logic [1:0]       level;
  } core_t;

  core_t core_reg;
  core_t core_next;

  serial_byte_if link ();

  uart_byte_rx u_rx (
    .mclk      (mclk),
    .rst       (rst),
    .serial_rx (serial_rx),
    .link      (link)
  );

  uart_byte_tx u_tx (
    .mclk      (mclk),
    .rst       (rst),
    .serial_tx (serial_tx),
    .link      (link)
  );

  // Bit period follows the baud strap; the slow one is long enough to
  // need shortening in simulation
  assign link.bit_cycles = baud_select ?
    uart_cfg_pkg::BIT_CNT_W'(uart_cfg_pkg::FAST_BIT_CYCLES) :
    uart_cfg_pkg::BIT_CNT_W'(SLOW_BIT_CYCLES);
  assign link.tx_valid = (core_reg.st == S_TX);
  assign link.tx_data  = core_reg.tx_byte;

  logic [1:0]  cmd_op;
  logic [5:0]  cmd_addr;
  logic [7:0]  mode;
  logic [7:0]  sum_step;
  logic [47:0][7:0] keep_ee;

  // Field split of the incoming command byte
  assign cmd_op   = link.rx_data[uart_cfg_pkg::OP_MSB:uart_cfg_pkg::OP_LSB];
  assign cmd_addr = link.rx_data[uart_cfg_pkg::ADDR_MSB:0];
  // Running config comes only from the boot copy, never the live array
  assign mode     = core_reg.cfg[uart_cfg_pkg::EE_MODE];
  assign sum_step = core_reg.sum + core_reg.ee[core_reg.idx];

  // Command sequencer, boot walk and runtime output selection
  always_comb begin
    core_next = core_reg;
    keep_ee = core_reg.ee;
    case (core_reg.st)
      S_BOOT: begin
        // One byte a cycle: copy into config and accumulate the sum
        core_next.cfg[core_reg.idx] = core_reg.ee[core_reg.idx];
        core_next.sum = sum_step;
        core_next.idx = core_reg.idx + 6'h01;
        if (core_reg.idx == uart_cfg_pkg::EE_LAST) begin
          core_next.idx = 6'h00;
          core_next.st = S_IDLE;
          core_next.fail = core_next.cfg[uart_cfg_pkg::EE_MODE]
                             [uart_cfg_pkg::MB_CHECKSUM] &&
                           (sum_step != uart_cfg_pkg::CHECKSUM_GOOD);
        end
      end
      S_IDLE: begin
        if (link.rx_valid) begin
          core_next.tx_left = uart_cfg_pkg::ONE_BYTE;
          core_next.after = S_IDLE;
          case (cmd_op)
            uart_cfg_pkg::OP_RAM_READ: begin
              core_next.tx_byte = core_reg.ram[cmd_addr];
              core_next.st = S_TX;
            end
            uart_cfg_pkg::OP_EE_READ: begin
              if (cmd_addr == uart_cfg_pkg::RESET_ADDR) begin
                core_next.tx_byte = uart_cfg_pkg::ACK_BYTE;
                core_next.after = S_SOFT;
                core_next.st = S_TX;
              end else if (cmd_addr <= uart_cfg_pkg::EE_LAST) begin
                core_next.tx_byte = core_reg.ee[cmd_addr];
                core_next.st = S_TX;
              end
            end
            default: begin
              // Both writes: echo only if the address exists
              if (cmd_op == uart_cfg_pkg::OP_RAM_WRITE ||
                  cmd_addr <= uart_cfg_pkg::EE_LAST) begin
                core_next.tx_byte = link.rx_data;
                core_next.idx = cmd_addr;
                core_next.wr_ee = (cmd_op == uart_cfg_pkg::OP_EE_WRITE);
                core_next.after = S_WDATA;
                core_next.st = S_TX;
              end
            end
          endcase
        end
      end
      S_TX: begin
        // Host is quiet while we talk, so received bytes are dropped here
        if (link.tx_ready) begin
          core_next.tx_left = core_reg.tx_left - 2'h1;
          if (core_reg.tx_left == uart_cfg_pkg::ONE_BYTE) begin
            core_next.st = core_reg.after;
          end
        end
      end
      S_WDATA: begin
        // Data byte only follows the echo, so the next byte is data
        if (link.rx_valid) begin
          if (core_reg.wr_ee) begin
            core_next.ee[core_reg.idx] = link.rx_data;
          end else begin
            core_next.ram[core_reg.idx] = link.rx_data;
          end
          core_next.tx_byte = uart_cfg_pkg::ACK_BYTE;
          core_next.tx_left = uart_cfg_pkg::ACK_COUNT;
          core_next.after = S_IDLE;
          core_next.st = S_TX;
        end
      end
      default: core_next.st = S_SOFT;
    endcase

    // Clock trim: boot value until the walk ends, then temperature range
    if (core_reg.st == S_BOOT) begin
      core_next.trim = core_reg.ee[uart_cfg_pkg::EE_BOOT_TRIM];
    end else if (internal_temp_adc[15:8] <
                 core_reg.cfg[uart_cfg_pkg::EE_THRESH_LOW]) begin
      core_next.trim = core_reg.cfg[uart_cfg_pkg::EE_TRIM_LOW];
    end else if (internal_temp_adc[15:8] <
                 core_reg.cfg[uart_cfg_pkg::EE_THRESH_HI]) begin
      core_next.trim = core_reg.cfg[uart_cfg_pkg::EE_TRIM_MID];
    end else begin
      core_next.trim = core_reg.cfg[uart_cfg_pkg::EE_TRIM_HIGH];
    end

    // Level indication counts how many of three transitions are passed
    core_next.level = 2'(
      {1'b0, signal_level >= core_reg.cfg[uart_cfg_pkg::EE_LIM_LO_TRG]} +
      {1'b0, signal_level >= core_reg.cfg[uart_cfg_pkg::EE_LIM_LO_OUT]} +
      {1'b0, signal_level >= core_reg.cfg[uart_cfg_pkg::EE_LIM_HI_TRG]});

    // Override priority: checksum fault, then limiting; steering shares
    // the limit bytes so limiting stands down while it is on
    core_next.override = 1'b0;
    core_next.value = 10'h000;
    if (core_reg.fail) begin
      core_next.override = 1'b1;
      core_next.value = {core_reg.cfg[uart_cfg_pkg::EE_FAULT_HIGH][1:0],
                         core_reg.cfg[uart_cfg_pkg::EE_FAULT_LOW]};
    end else if (mode[uart_cfg_pkg::MB_LIMIT] &&
                 !mode[uart_cfg_pkg::MB_STEER] &&
                 core_reg.st != S_BOOT) begin
      if (signal_level < core_reg.cfg[uart_cfg_pkg::EE_LIM_LO_TRG]) begin
        core_next.override = 1'b1;
        core_next.value = {core_reg.cfg[uart_cfg_pkg::EE_LIM_LO_OUT], 2'h0};
      end else if (signal_level >
                   core_reg.cfg[uart_cfg_pkg::EE_LIM_HI_TRG]) begin
        core_next.override = 1'b1;
        core_next.value = {core_reg.cfg[uart_cfg_pkg::EE_LIM_HI_OUT], 2'h0};
      end
    end

    // Live measurements overwrite their RAM slots every cycle, high first
    core_next.ram[uart_cfg_pkg::RAM_INT_TEMP_HI] =
      internal_temp_adc[15:8];
    core_next.ram[uart_cfg_pkg::RAM_INT_TEMP_LO] = internal_temp_adc[7:0];
    core_next.ram[uart_cfg_pkg::RAM_FILT_TEMP_HI] =
      filtered_temp[9:2];
    core_next.ram[uart_cfg_pkg::RAM_FILT_TEMP_LO] =
      {filtered_temp[1:0], 6'h00};
    core_next.ram[uart_cfg_pkg::RAM_GAIN_HI] = gain_stage_adc[15:8];
    core_next.ram[uart_cfg_pkg::RAM_GAIN_LO] = gain_stage_adc[7:0];
    core_next.ram[uart_cfg_pkg::RAM_AUX_IN] =
      {6'h00, aux_pin_b_in, aux_pin_a_in};

    // Soft reset keeps EEPROM contents; power reset has no stored image
    if (rst || core_reg.st == S_SOFT) begin
      keep_ee = rst ? '0 : core_reg.ee;
      core_next = '0;
      core_next.st = S_BOOT;
      core_next.after = S_IDLE;
      core_next.ee = keep_ee;
    end
  end

  always_ff @(posedge mclk) begin
    core_reg <= core_next;
  end

  // Mode decode straight from the boot copy
  assign config_ready          = (core_reg.st != S_BOOT);
  assign checksum_fail         = core_reg.fail;
  assign digital_mode          = mode[uart_cfg_pkg::MB_DIGITAL];
  assign mode_conflict         = mode[uart_cfg_pkg::MB_VOUT] &&
                                 mode[uart_cfg_pkg::MB_IOUT] &&
                                 !mode[uart_cfg_pkg::MB_DIGITAL];
  assign limit_enable          = mode[uart_cfg_pkg::MB_LIMIT];
  assign level_steer_enable    = mode[uart_cfg_pkg::MB_STEER];
  assign turbo_enable          = mode[uart_cfg_pkg::MB_TURBO];
  assign voltage_output_enable = mode[uart_cfg_pkg::MB_VOUT];
  assign current_loop_output_enable = mode[uart_cfg_pkg::MB_IOUT];
  assign external_temp_select  = mode[uart_cfg_pkg::MB_EXT_TEMP];
  assign current_loop_fixed    = mode[uart_cfg_pkg::MB_IOUT] &&
                                 mode[uart_cfg_pkg::MB_VOUT] &&
                                 mode[uart_cfg_pkg::MB_DIGITAL];
  assign current_loop_value    =
    {core_reg.cfg[uart_cfg_pkg::EE_CLOOP_HIGH][1:0],
     core_reg.cfg[uart_cfg_pkg::EE_CLOOP_LOW]};

  // Aux pins: driven only while steering, otherwise left as inputs
  assign aux_pin_a_out  = core_reg.level[0];
  assign aux_pin_b_out  = core_reg.level[1];
  assign aux_pin_a_oe_n = !mode[uart_cfg_pkg::MB_STEER];
  assign aux_pin_b_oe_n = !mode[uart_cfg_pkg::MB_STEER];

  // Shared high byte: upper nibble gain, lower nibble offset
  assign gain_tc1   = {core_reg.cfg[uart_cfg_pkg::EE_TC1_HIGH][7:4],
                       core_reg.cfg[uart_cfg_pkg::EE_GNTC1_LOW]};
  assign offset_tc1 = {core_reg.cfg[uart_cfg_pkg::EE_TC1_HIGH][3:0],
                       core_reg.cfg[uart_cfg_pkg::EE_OFTC1_LOW]};

  assign digital_output_override = core_reg.override;
  assign output_value            = core_reg.value;
  assign clock_trim              = core_reg.trim;
endmodule
`default_nettype wire

// [logic/uart_cfg_pkg.sv]
// Constants shared by the serial configuration interpreter and its UART.
// Assumes a single 20 MHz clock and byte-wide command traffic.
package uart_cfg_pkg;

  // Clock and serial timing
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned BAUD_FAST       = 9600;
  localparam int unsigned BAUD_SLOW       = 2400;
  localparam int unsigned FAST_BIT_CYCLES = CLK_HZ / BAUD_FAST;
  localparam int unsigned SLOW_BIT_CYCLES = CLK_HZ / BAUD_SLOW;
  localparam int          BIT_CNT_W       = 14;
  localparam logic [3:0]  FRAME_LAST_BIT  = 4'h9;
  localparam logic [2:0]  DATA_LAST_BIT   = 3'h7;

  // Command byte layout and operation codes
  localparam int         OP_MSB       = 7;
  localparam int         OP_LSB       = 6;
  localparam int         ADDR_MSB     = 5;
  localparam logic [1:0] OP_RAM_READ  = 2'h3;
  localparam logic [1:0] OP_EE_READ   = 2'h2;
  localparam logic [1:0] OP_EE_WRITE  = 2'h1;
  localparam logic [1:0] OP_RAM_WRITE = 2'h0;

  // Memory sizes and special addresses
  localparam int         EE_SIZE       = 48;
  localparam int         RAM_SIZE      = 64;
  localparam logic [5:0] EE_LAST       = 6'h2f;
  localparam logic [5:0] RESET_ADDR    = 6'h3f;
  localparam logic [7:0] ACK_BYTE      = 8'hbc;
  localparam logic [7:0] CHECKSUM_GOOD = 8'hff;
  localparam logic [1:0] ACK_COUNT     = 2'h2;
  localparam logic [1:0] ONE_BYTE      = 2'h1;

  // EEPROM byte positions
  localparam int EE_MODE       = 0;
  localparam int EE_BOOT_TRIM  = 1;
  localparam int EE_GNTC1_LOW  = 5;
  localparam int EE_OFTC1_LOW  = 6;
  localparam int EE_TC1_HIGH   = 18;
  localparam int EE_LIM_LO_TRG = 27;
  localparam int EE_LIM_LO_OUT = 28;
  localparam int EE_LIM_HI_TRG = 29;
  localparam int EE_LIM_HI_OUT = 30;
  localparam int EE_TRIM_LOW   = 32;
  localparam int EE_TRIM_MID   = 33;
  localparam int EE_TRIM_HIGH  = 34;
  localparam int EE_THRESH_LOW = 35;
  localparam int EE_THRESH_HI  = 36;
  localparam int EE_FAULT_HIGH = 40;
  localparam int EE_FAULT_LOW  = 41;
  localparam int EE_CLOOP_HIGH = 42;
  localparam int EE_CLOOP_LOW  = 43;

  // Mode byte fields
  localparam int MB_CHECKSUM = 7;
  localparam int MB_DIGITAL  = 6;
  localparam int MB_LIMIT    = 5;
  localparam int MB_STEER    = 4;
  localparam int MB_TURBO    = 3;
  localparam int MB_VOUT     = 2;
  localparam int MB_EXT_TEMP = 1;
  localparam int MB_IOUT     = 0;

  // Live RAM bytes, high byte first
  localparam int RAM_INT_TEMP_HI  = 56;
  localparam int RAM_INT_TEMP_LO  = 57;
  localparam int RAM_FILT_TEMP_HI = 58;
  localparam int RAM_FILT_TEMP_LO = 59;
  localparam int RAM_GAIN_HI      = 60;
  localparam int RAM_GAIN_LO      = 61;
  localparam int RAM_AUX_IN       = 62;

endpackage

// [logic/serial_byte_if.sv]
// Byte-level link between the interpreter core and its UART halves.
// Assumes all three sides run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface serial_byte_if;
  logic                                 rx_valid;
  logic [7:0]                           rx_data;
  logic                                 tx_valid;
  logic                                 tx_ready;
  logic [7:0]                           tx_data;
  logic [uart_cfg_pkg::BIT_CNT_W-1:0]   bit_cycles;

  modport rx_side (output rx_valid, output rx_data, input bit_cycles);
  modport tx_side (input tx_valid, input tx_data, input bit_cycles,
                   output tx_ready);
  modport core    (input rx_valid, input rx_data, input tx_ready,
                   output tx_valid, output tx_data, output bit_cycles);
endinterface
`default_nettype wire

// [logic/uart_byte_rx.sv]
// UART receiver, 8N1, producing a one-cycle strobe per good frame.
// Assumes serial_rx is already synchronous to mclk; idle line is high.
`timescale 1ns/1ps
`default_nettype none
module uart_byte_rx (
  input  wire logic     mclk,
  input  wire logic     rst,
  input  wire logic     serial_rx,
  serial_byte_if.rx_side link
);
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } rx_state_t;

  typedef struct packed {
    rx_state_t                          st;
    logic [uart_cfg_pkg::BIT_CNT_W-1:0] cnt;
    logic [2:0]                         bitn;
    logic [7:0]                         sh;
    logic                               valid;
    logic [7:0]                         data;
  } rx_t;

  rx_t rx_reg;
  rx_t rx_next;

  // Sampling at mid-bit tolerates the clock drift the trim table leaves
  always_comb begin
    rx_next = rx_reg;
    rx_next.valid = 1'b0;
    case (rx_reg.st)
      RX_IDLE: begin
        if (!serial_rx) begin
          rx_next.cnt = link.bit_cycles >> 1;
          rx_next.st = RX_START;
        end
      end
      RX_START: begin
        if (rx_reg.cnt == '0) begin
          rx_next.cnt = link.bit_cycles - 1'b1;
          rx_next.bitn = 3'h0;
          rx_next.st = serial_rx ? RX_IDLE : RX_DATA; // Glitch rejected
        end else begin
          rx_next.cnt = rx_reg.cnt - 1'b1;
        end
      end
      RX_DATA: begin
        if (rx_reg.cnt == '0) begin
          rx_next.sh = {serial_rx, rx_reg.sh[7:1]};
          rx_next.cnt = link.bit_cycles - 1'b1;
          rx_next.bitn = rx_reg.bitn + 3'h1;
          if (rx_reg.bitn == uart_cfg_pkg::DATA_LAST_BIT) begin
            rx_next.st = RX_STOP;
          end
        end else begin
          rx_next.cnt = rx_reg.cnt - 1'b1;
        end
      end
      RX_STOP: begin
        if (rx_reg.cnt == '0) begin
          rx_next.valid = serial_rx; // Framing error drops the byte
          rx_next.data = rx_reg.sh;
          rx_next.st = RX_IDLE;
        end else begin
          rx_next.cnt = rx_reg.cnt - 1'b1;
        end
      end
      default: rx_next.st = RX_IDLE;
    endcase
    if (rst) begin
      rx_next = '0;
      rx_next.st = RX_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    rx_reg <= rx_next;
  end

  assign link.rx_valid = rx_reg.valid;
  assign link.rx_data  = rx_reg.data;
endmodule
`default_nettype wire

// [logic/uart_byte_tx.sv]
// UART transmitter, 8N1, with a valid/ready byte handshake.
// Assumes the core holds tx_data steady while tx_valid is high.
`timescale 1ns/1ps
`default_nettype none
module uart_byte_tx (
  input  wire logic     mclk,
  input  wire logic     rst,
  output logic          serial_tx,
  serial_byte_if.tx_side link
);
  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,
    TX_SEND = 2'h2
  } tx_state_t;

  typedef struct packed {
    tx_state_t                          st;
    logic [uart_cfg_pkg::BIT_CNT_W-1:0] cnt;
    logic [3:0]                         bitn;
    logic [9:0]                         sh;
    logic                               line;
  } tx_t;

  tx_t tx_reg;
  tx_t tx_next;

  // Frame is shifted LSB first: start, eight data bits, stop
  always_comb begin
    tx_next = tx_reg;
    case (tx_reg.st)
      TX_IDLE: begin
        tx_next.line = 1'b1;
        if (link.tx_valid) begin
          tx_next.sh = {1'b1, link.tx_data, 1'b0};
          tx_next.cnt = link.bit_cycles - 1'b1;
          tx_next.bitn = 4'h0;
          tx_next.line = 1'b0;
          tx_next.st = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tx_reg.cnt == '0) begin
          tx_next.sh = {1'b1, tx_reg.sh[9:1]};
          tx_next.bitn = tx_reg.bitn + 4'h1;
          tx_next.cnt = link.bit_cycles - 1'b1;
          tx_next.line = tx_reg.sh[1];
          if (tx_reg.bitn == uart_cfg_pkg::FRAME_LAST_BIT) begin
            tx_next.line = 1'b1;
            tx_next.st = TX_IDLE;
          end
        end else begin
          tx_next.cnt = tx_reg.cnt - 1'b1;
        end
      end
      default: tx_next.st = TX_IDLE;
    endcase
    if (rst) begin
      tx_next = '0;
      tx_next.st = TX_IDLE;
      tx_next.line = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    tx_reg <= tx_next;
  end

  assign link.tx_ready = (tx_reg.st == TX_IDLE);
  assign serial_tx     = tx_reg.line;
endmodule
`default_nettype wire

// [bench/cmd_interp_checker.sv]
// Port-level assertions for the serial configuration interpreter.
// Assumes one mclk domain and a synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module cmd_interp_checker #(
  parameter int unsigned SLOW_BIT_CYCLES = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic serial_tx,
  input wire logic config_ready,
  input wire logic checksum_fail,
  input wire logic digital_mode,
  input wire logic mode_conflict,
  input wire logic voltage_output_enable,
  input wire logic current_loop_output_enable,
  input wire logic current_loop_fixed,
  input wire logic level_steer_enable,
  input wire logic aux_pin_a_oe_n,
  input wire logic digital_output_override
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Boot walk keeps the block busy before commands are taken
  sequence boot_walk;
    !config_ready [*8] ##[39:42] config_ready;
  endsequence
  // A frame opens with a start bit that stays low for at least 8 cycles
  sequence start_bit;
    !serial_tx [*8];
  endsequence
  a_tx_idle_reset: assert property ($fell(rst) |-> serial_tx)
    else $error("tx not idle after reset");
  a_boot_walk: assert property ($fell(rst) |-> boot_walk)
    else $error("boot walk length wrong");
  a_start_bit: assert property ($fell(serial_tx) |-> start_bit)
    else $error("start bit too short");
  a_mode_conflict: assert property (mode_conflict == (voltage_output_enable
    && current_loop_output_enable && !digital_mode))
    else $error("conflict flag wrong");
  a_loop_fixed: assert property (current_loop_fixed == (digital_mode &&
    voltage_output_enable && current_loop_output_enable))
    else $error("fixed loop flag wrong");
  a_steer_oe: assert property (aux_pin_a_oe_n == !level_steer_enable)
    else $error("aux enable wrong");
  a_fail_override: assert property (checksum_fail && config_ready |->
    ##[0:2] digital_output_override)
    else $error("fault not forced");
  a_cfg_stable: assert property (config_ready && $past(config_ready) |->
    $stable({digital_mode, voltage_output_enable, checksum_fail}))
    else $error("config moved without reset");
endmodule
bind uart_config_command_interpreter cmd_interp_checker #(
  .SLOW_BIT_CYCLES(SLOW_BIT_CYCLES)) cmd_interp_checker_i (.*);
`default_nettype wire

// [bench/host_uart.sv]
// Calibration host model: sends and receives 8N1 frames.
// Assumes bit time of B clocks; line idles high between frames.
`timescale 1ns/1ps
`default_nettype none
module host_uart #(
  parameter int B = 16
) (
  input  wire logic mclk,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;
  // Returns early in the stop bit so the reply start is not missed
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out = f[i];
      repeat (i == 9 ? B / 4 : B) @(negedge mclk);
    end
  endtask
  // Gives x when no frame starts within the wait limit
  task automatic recv(output logic [7:0] b);
    int n;
    n = 0;
    b = 8'hxx;
    while (line_in === 1'b1 && n < 40 * B) begin
      @(negedge mclk);
      n++;
    end
    if (n < 40 * B) begin
      repeat (B / 2) @(negedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (B) @(negedge mclk);
        b[i] = line_in;
      end
      repeat (B) @(negedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench driving the interpreter through its serial port.
// Assumes SLOW_BIT_CYCLES of 16 and baud_select low.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk, rst, rx, tx, ready, fail, dig, ovr;
  logic pin_a, pin_b, ext, fix, oea, oeb, auxa, auxb;
  logic [7:0] sig, trim;
  logic [15:0] temp;
  logic [9:0] outv, loopv;
  logic [11:0] gtc, otc;
  int mismatches = 0;
  int num_checks = 0;
  host_uart #(.B(16)) host_uart_i (.mclk(mclk), .line_in(tx),
    .line_out(rx));
  uart_config_command_interpreter #(.SLOW_BIT_CYCLES(16))
    uart_config_command_interpreter_i (.mclk(mclk), .rst(rst),
    .serial_rx(rx), .serial_tx(tx), .baud_select(1'b0),
    .internal_temp_adc(temp), .filtered_temp(10'h2a5),
    .gain_stage_adc(16'hbeef), .signal_level(sig), .aux_pin_a_in(pin_a),
    .aux_pin_b_in(pin_b), .aux_pin_a_out(auxa), .aux_pin_a_oe_n(oea),
    .aux_pin_b_out(auxb), .aux_pin_b_oe_n(oeb), .config_ready(ready),
    .checksum_fail(fail), .digital_mode(dig), .mode_conflict(),
    .limit_enable(), .level_steer_enable(), .turbo_enable(),
    .voltage_output_enable(), .current_loop_output_enable(),
    .external_temp_select(ext), .current_loop_fixed(fix),
    .current_loop_value(loopv), .digital_output_override(ovr),
    .output_value(outv), .clock_trim(trim), .gain_tc1(gtc),
    .offset_tc1(otc));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
      mismatches++;
    end
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] b;
    host_uart_i.send(cmd);
    host_uart_i.recv(b);
    check(b, exp);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    logic [7:0] b;
    host_uart_i.send(cmd);
    host_uart_i.recv(b);
    check(b, cmd);
    host_uart_i.send(d);
    for (int i = 0; i < 2; i++) begin
      host_uart_i.recv(b);
      check(b, 8'hbc);
    end
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Timeout guard, well above the expected run of some 20000 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    print_verdict;
  end
  // Main sequence: reset, accesses, soft resets around checksum setup
  initial begin
    rst = 1'b1;
    temp = 16'h1234;
    sig = 8'h80;
    pin_a = 1'b1;
    pin_b = 1'b0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (60) @(negedge mclk);
    check(ready, 1'b1);
    wr(8'h40, 8'h40);
    check(dig, 1'b0);
    rd(8'h80, 8'h40);
    wr(8'h05, 8'ha5);
    rd(8'hc5, 8'ha5);
    rd(8'hfa, 8'ha9);
    rd(8'hfb, 8'h40);
    rd(8'hfc, 8'hbe);
    rd(8'hf8, 8'h12);
    rd(8'hfe, 8'h01);
    rd(8'hb0, 8'hxx);
    rd(8'hbf, 8'hbc);
    check(dig, 1'b1);
    wr(8'h40, 8'hc0);
    wr(8'h68, 8'h01);
    wr(8'h69, 8'h23);
    rd(8'hbf, 8'hbc);
    check({fail, ovr}, 2'h3);
    check(outv, 10'h123);
    wr(8'h6f, 8'h1b);
    rd(8'hbf, 8'hbc);
    check(fail, 1'b0);
    // Mode: digital, limit, vout, external temp, iout; then table bytes
    wr(8'h40, 8'h67);
    wr(8'h41, 8'h9a);
    wr(8'h5b, 8'h40);
    wr(8'h5c, 8'h11);
    wr(8'h5d, 8'hc0);
    wr(8'h5e, 8'h3e);
    wr(8'h60, 8'h51);
    wr(8'h61, 8'h62);
    wr(8'h62, 8'h73);
    wr(8'h63, 8'h20);
    wr(8'h64, 8'h40);
    wr(8'h52, 8'h9c);
    wr(8'h6b, 8'h55);
    // Reset by hand so the boot trim is seen while the walk runs
    host_uart_i.send(8'hbf);
    while (ready) @(negedge mclk);
    repeat (4) @(negedge mclk);
    check(trim, 8'h9a);
    repeat (200) @(negedge mclk);
    check({dig, ext, fix, oea}, 4'hf);
    check(loopv, 10'h055);
    check(gtc, 12'h900);
    check(otc, 12'hc00);
    check({ovr, outv}, 11'h000);
    check(trim, 8'h51);
    temp = 16'h3000;
    repeat (2) @(negedge mclk);
    check(trim, 8'h62);
    temp = 16'h5000;
    sig = 8'h10;
    repeat (2) @(negedge mclk);
    check(trim, 8'h73);
    check({ovr, outv}, 11'h444);
    sig = 8'hf0;
    repeat (2) @(negedge mclk);
    check({ovr, outv}, 11'h4f8);
    // Steering on: limiting stands down even above the high trigger
    wr(8'h40, 8'h30);
    rd(8'hbf, 8'hbc);
    check({auxb, auxa, oea, oeb, ovr}, 5'h18);
    sig = 8'h20;
    repeat (2) @(negedge mclk);
    check({auxb, auxa}, 2'h1);
    print_verdict;
  end
endmodule
`default_nettype wire
